// ==== sram_ctrl_model.sv ====
// Memory-controller model driving the SRAM port's pins.
// Assumes one cmd call per clock; pins change 1 ns after the edge.
`timescale 1ns/1ps
module sram_ctrl_model (
    input  wire logic   clk_in,
    output logic        clock_qualify_n_in,
    output logic        chip_select_first_n_in,
    output logic        chip_select_second_in,
    output logic        chip_select_third_n_in,
    output logic        write_select_n_in,
    output logic        advance_or_load_in,
    output logic [3:0]  byte_write_select_n_in,
    output logic [5:0]  addr_in,
    output logic        output_enable_n_in,
    output logic [31:0] data_io_in,
    output logic [3:0]  parity_io_in
);
    logic        wr_next;
    logic        burst_wr;
    logic [35:0] wd_next;
    // Kinds: 0 deselect, 1 read, 2 write, 3 advance, 4 stalled write,
    // 5..7 read with one chip select inactive
    task automatic put(input int k, input logic [5:0] a,
                       input logic [3:0] b, input logic [35:0] d);
        clock_qualify_n_in     = (k == 4);
        chip_select_first_n_in = (k == 0 || k == 5);
        chip_select_second_in  = (k != 6);
        chip_select_third_n_in = (k == 7);
        write_select_n_in      = !(k == 2 || k == 4);
        advance_or_load_in     = (k == 3);
        byte_write_select_n_in = b;
        addr_in                = a;
        // Bus driven only in a write data phase, else left moving
        if (wr_next)
            {parity_io_in, data_io_in} = wd_next;
        else
            {parity_io_in, data_io_in} = ~{parity_io_in, data_io_in};
        if (k == 2 || k == 1)
            burst_wr = (k == 2);
        wr_next = (k == 2) || (k == 3 && burst_wr);
        wd_next = d;
    endtask
    task automatic cmd(input int k, input logic [5:0] a,
                       input logic [3:0] b, input logic [35:0] d);
        @(posedge clk_in);
        #1;
        put(k, a, b, d);
    endtask
    task automatic set_oe(input logic v);
        output_enable_n_in = v;
    endtask
    initial
    begin
        wr_next = 1'b0;
        burst_wr = 1'b0;
        {parity_io_in, data_io_in} = '0;
        output_enable_n_in = 1'b0;
        put(0, '0, 4'hF, '0);
    end
endmodule

// ==== sram_port.sv ====
// Flow-through burst SRAM device logic behind its pins.
// Assumes pins synchronised here; memory array is a flip-flop model.
`timescale 1ns/1ps
module sram_port
    import sram_port_pkg::*;
#(
    parameter int LANES     = sram_port_pkg::LANES_WIDE,
    parameter int ADDR_BITS = 6,
    parameter int DEPTH     = sram_port_pkg::FIFO_DEPTH
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_in,
    input  wire logic                 clock_qualify_n_in,
    input  wire logic                 chip_select_first_n_in,
    input  wire logic                 chip_select_second_in,
    input  wire logic                 chip_select_third_n_in,
    input  wire logic                 write_select_n_in,
    input  wire logic                 advance_or_load_in,
    input  wire logic [LANES-1:0]     byte_write_select_n_in,
    input  wire logic [ADDR_BITS-1:0] addr_in,
    input  wire logic                 output_enable_n_in,
    input  wire logic                 burst_order_in,
    input  wire logic                 sleep_request_in,
    input  wire logic [LANES*8-1:0]   data_io_in,
    input  wire logic [LANES-1:0]     parity_io_in,
    output logic [LANES*8-1:0]        data_io_out,
    output logic [LANES-1:0]          parity_io_out,
    output logic                      data_io_oe_out,
    output logic                      sleeping_out
);
    import sram_port_pkg::*;

    localparam int LW = LANE_DATA_BITS + 1;
    localparam int WW = LANES * LW;
    localparam int FW = ADDR_BITS + LANES + WW;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [6:0] ctl_meta_q;
    logic [6:0] ctl_q;
    logic [LANES-1:0] bws_meta_q;
    logic [LANES-1:0] bws_n_q;
    logic [ADDR_BITS-1:0] addr_meta_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic [WW-1:0] din_meta_q;
    logic [WW-1:0] din_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ctl_meta_q  <= 7'h01;
            ctl_q       <= 7'h01;
            bws_meta_q  <= '1;
            bws_n_q     <= '1;
            addr_meta_q <= '0;
            addr_q      <= '0;
            din_meta_q  <= '0;
            din_q       <= '0;
        end
        else
        begin
            ctl_meta_q  <= {sleep_request_in, burst_order_in,
                            advance_or_load_in, write_select_n_in,
                            chip_select_third_n_in, chip_select_second_in,
                            clock_qualify_n_in};
            ctl_q       <= ctl_meta_q;
            bws_meta_q  <= byte_write_select_n_in;
            bws_n_q     <= bws_meta_q;
            addr_meta_q <= addr_in;
            addr_q      <= addr_meta_q;
            din_meta_q  <= {parity_io_in, data_io_in};
            din_q       <= din_meta_q;
        end
    end

    // First chip select kept apart to keep vector order readable
    logic cs1_meta_q;
    logic cs1_n_q;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cs1_meta_q <= 1'b1;
            cs1_n_q    <= 1'b1;
        end
        else
        begin
            cs1_meta_q <= chip_select_first_n_in;
            cs1_n_q    <= cs1_meta_q;
        end
    end

    // Output enable synchronised like every other pin
    logic oe_meta_n_q;
    logic oe_n_q;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            oe_meta_n_q <= 1'b1;
            oe_n_q      <= 1'b1;
        end
        else
        begin
            oe_meta_n_q <= output_enable_n_in;
            oe_n_q      <= oe_meta_n_q;
        end
    end

    phase_t ph_q;
    logic qual_n;
    logic cs2;
    logic cs3_n;
    logic we_n;
    logic adv;
    logic order_il;
    logic sleep_req;
    logic edge_ok;
    logic selected;

    assign qual_n    = ctl_q[0];
    assign cs2       = ctl_q[1];
    assign cs3_n     = ctl_q[2];
    assign we_n      = ctl_q[3];
    assign adv       = ctl_q[4];
    assign order_il  = ctl_q[5];
    assign sleep_req = ctl_q[6];
    assign selected  = !cs1_n_q && cs2 && !cs3_n;
    assign edge_ok   = !qual_n && (ph_q != PH_SLEEP);

    // ************************************************************
    // Sleep sequencing
    // ************************************************************
    logic [SLEEP_CNT_BITS-1:0] sleep_cnt_q;
    logic sleep_stable_q;

    // Sleep request must be steady SLEEP_CYCLES edges to take effect
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sleep_cnt_q    <= SLEEP_CNT_RESET;
            sleep_stable_q <= 1'b0;
        end
        else if (sleep_req == sleep_stable_q)
        begin
            sleep_cnt_q <= SLEEP_CNT_RESET;
        end
        else if (sleep_cnt_q == SLEEP_CNT_BITS'(SLEEP_CYCLES - 1))
        begin
            sleep_cnt_q    <= SLEEP_CNT_RESET;
            sleep_stable_q <= sleep_req;
        end
        else
        begin
            sleep_cnt_q <= SLEEP_CNT_BITS'(sleep_cnt_q + 1'b1);
        end
    end

    // ************************************************************
    // Operation phase and burst control
    // ************************************************************
    logic [ADDR_BITS-1:0]  base_q;
    logic [BURST_BITS-1:0] offs_q;
    logic                  il_q;
    logic                  first_q;
    logic [BURST_BITS-1:0] low_addr;
    logic [ADDR_BITS-1:0]  cur_addr;

    always_comb
    begin
        if (il_q)
        begin
            low_addr = base_q[BURST_BITS-1:0] ^ offs_q;
        end
        else
        begin
            low_addr = BURST_BITS'(base_q[BURST_BITS-1:0] + offs_q);
        end
    end
    assign cur_addr = {base_q[ADDR_BITS-1:BURST_BITS], low_addr};

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ph_q    <= PH_IDLE;
            base_q  <= '0;
            offs_q  <= '0;
            il_q    <= 1'b1;
            first_q <= 1'b0;
        end
        else if (sleep_stable_q)
        begin
            ph_q    <= PH_SLEEP;
            first_q <= 1'b0;
        end
        else if (ph_q == PH_SLEEP)
        begin
            ph_q <= PH_IDLE;
        end
        else if (edge_ok)
        begin
            first_q <= 1'b0;
            if (adv)
            begin
                offs_q <= BURST_BITS'(offs_q + 1'b1);
            end
            else if (!selected)
            begin
                ph_q <= PH_IDLE;
            end
            else
            begin
                base_q  <= addr_q;
                offs_q  <= '0;
                il_q    <= order_il;
                first_q <= (ph_q == PH_IDLE);
                ph_q    <= we_n ? PH_READ : PH_WRITE;
            end
        end
    end

    // ************************************************************
    // Write path through FIFO into the array
    // ************************************************************
    logic [LANES-1:0] lanes_q;
    logic [FW-1:0]    fifo_rd;
    logic             fifo_rd_valid;
    logic             push;
    logic [WW-1:0]    mem_q [2**ADDR_BITS];

    // Data phase: write decided last edge, beat completes this edge
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            lanes_q <= '0;
        end
        else if (edge_ok)
        begin
            lanes_q <= ~bws_n_q;
        end
    end

    assign push = edge_ok && (ph_q == PH_WRITE) && (lanes_q != '0);

    word_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .wr_data_in   ({cur_addr, lanes_q, din_q}),
        .wr_valid_in  (push),
        .wr_ready_out (),
        .rd_data_out  (fifo_rd),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (1'b1)
    );

    logic [ADDR_BITS-1:0] wr_addr;
    logic [WW-1:0]        old_word;
    wire logic [WW-1:0]   merge_word;

    assign wr_addr  = fifo_rd[FW-1:WW+LANES];
    assign old_word = mem_q[wr_addr];

    // Unselected lanes keep the stored byte and parity bit
    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            assign merge_word[g*LANE_DATA_BITS +: LANE_DATA_BITS] =
                fifo_rd[WW+g] ? fifo_rd[g*LANE_DATA_BITS +: LANE_DATA_BITS]
                              : old_word[g*LANE_DATA_BITS +: LANE_DATA_BITS];
            assign merge_word[LANES*LANE_DATA_BITS+g] =
                fifo_rd[WW+g] ? fifo_rd[LANES*LANE_DATA_BITS+g]
                              : old_word[LANES*LANE_DATA_BITS+g];
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        if (fifo_rd_valid)
        begin
            mem_q[wr_addr] <= merge_word;
        end
    end

    // ************************************************************
    // Read data and output drivers
    // ************************************************************
    logic [WW-1:0] rdata_q;
    logic          drive_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= mem_q[cur_addr];
        end
    end

    // Drive flag stays in step with the read data it qualifies
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            drive_q <= 1'b0;
        end
        else
        begin
            drive_q <= (ph_q == PH_READ) && !first_q
                       && !oe_n_q;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            data_io_out    <= '0;
            parity_io_out  <= '0;
            data_io_oe_out <= 1'b0;
            sleeping_out   <= 1'b0;
        end
        else
        begin
            data_io_out    <= rdata_q[LANES*LANE_DATA_BITS-1:0];
            parity_io_out  <= rdata_q[WW-1:LANES*LANE_DATA_BITS];
            data_io_oe_out <= drive_q;
            sleeping_out   <= (ph_q == PH_SLEEP);
        end
    end

endmodule

// ==== sram_port_pkg.sv ====
// Constants and types shared by the flow-through burst SRAM port.
// Assumes a single 50 MHz clock domain with an active-high async reset.
package sram_port_pkg;

    // ************************************************************
    // Geometry
    // ************************************************************
    localparam int LANE_DATA_BITS = 8;
    localparam int LANES_WIDE     = 4;
    localparam int LANES_NARROW   = 2;
    localparam int ADDR_BITS_WIDE = 19;
    localparam int BURST_LEN      = 4;
    localparam int BURST_BITS     = 2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 20;
    localparam int SLEEP_CYCLES   = 2;
    localparam int SLEEP_CNT_BITS = 2;
    localparam logic [SLEEP_CNT_BITS-1:0] SLEEP_CNT_RESET = 2'h0;

    // ************************************************************
    // Buffering
    // ************************************************************
    localparam int FIFO_DEPTH = 32;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        PH_IDLE  = 4'h1,
        PH_READ  = 4'h2,
        PH_WRITE = 4'h4,
        PH_SLEEP = 4'h8
    } phase_t;

endpackage

// ==== sram_port_properties.sv ====
// Pin-level checks on the burst SRAM port.
// Assumes it is bound to sram_port; one clock, async high reset.
`timescale 1ns/1ps
module sram_port_checker #(
    parameter int LANES     = 4,
    parameter int ADDR_BITS = 6
) (
    input wire logic               clk_in,
    input wire logic               rst_in,
    input wire logic               clock_qualify_n_in,
    input wire logic               chip_select_first_n_in,
    input wire logic               chip_select_second_in,
    input wire logic               chip_select_third_n_in,
    input wire logic               write_select_n_in,
    input wire logic               advance_or_load_in,
    input wire logic               output_enable_n_in,
    input wire logic               sleep_request_in,
    input wire logic [LANES*8-1:0] data_io_out,
    input wire logic               data_io_oe_out,
    input wire logic               sleeping_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [3:0] quiet_q, oe_hi_q, stall_q, sl_hi_q, sl_lo_q;
    logic       oe_n_q, sel, rd_like;
    assign sel = !chip_select_first_n_in && chip_select_second_in
                 && !chip_select_third_n_in;
    // Anything that may start or keep a read going
    assign rd_like = clock_qualify_n_in || advance_or_load_in
                     || (sel && write_select_n_in);
    function automatic logic [3:0] inc(input logic [3:0] v);
        return (v == 4'hF) ? v : v + 4'h1;
    endfunction
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            quiet_q <= 4'h0;
            oe_hi_q <= 4'h0;
            stall_q <= 4'h0;
            sl_hi_q <= 4'h0;
            sl_lo_q <= 4'h0;
            oe_n_q  <= 1'b1;
        end
        else
        begin
            quiet_q <= rd_like ? 4'h0 : inc(quiet_q);
            oe_hi_q <= output_enable_n_in ? inc(oe_hi_q) : 4'h0;
            stall_q <= (clock_qualify_n_in && !sleep_request_in
                        && output_enable_n_in == oe_n_q) ? inc(stall_q) : 4'h0;
            sl_hi_q <= sleep_request_in ? inc(sl_hi_q) : 4'h0;
            sl_lo_q <= sleep_request_in ? 4'h0 : inc(sl_lo_q);
            oe_n_q  <= output_enable_n_in;
        end
    end
    property p_reset_clear;
        $fell(rst_in) |-> !data_io_oe_out && !sleeping_out && data_io_out == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not idle after reset");
    property p_oe_gated;
        oe_hi_q >= 4'h4 |-> !data_io_oe_out;
    endproperty
    a_oe_gated: assert property (p_oe_gated)
        else $error("driving with output enable high");
    property p_quiet_no_drive;
        quiet_q >= 4'h7 |-> !data_io_oe_out;
    endproperty
    a_quiet_no_drive: assert property (p_quiet_no_drive)
        else $error("driving without a read");
    property p_deselect_drop;
        (!clock_qualify_n_in && !advance_or_load_in && !sel)[*2]
            |-> ##[1:5] !data_io_oe_out;
    endproperty
    a_deselect_drop: assert property (p_deselect_drop)
        else $error("still driving after deselect");
    property p_stall_holds;
        stall_q >= 4'h5 |-> $stable(data_io_out) && $stable(data_io_oe_out);
    endproperty
    a_stall_holds: assert property (p_stall_holds)
        else $error("outputs moved during stall");
    property p_sleep_enter;
        sl_hi_q >= 4'h8 |-> sleeping_out;
    endproperty
    a_sleep_enter: assert property (p_sleep_enter)
        else $error("sleep not entered");
    property p_sleep_exit;
        sl_lo_q >= 4'h8 |-> !sleeping_out;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("sleep not left");
    property p_sleep_no_drive;
        sleeping_out && $past(sleeping_out) |-> !data_io_oe_out;
    endproperty
    a_sleep_no_drive: assert property (p_sleep_no_drive)
        else $error("driving while asleep");
endmodule

bind sram_port sram_port_checker #(.LANES(LANES), .ADDR_BITS(ADDR_BITS))
    i_sram_port_checker (.*);

// ==== sram_port_tb_top.sv ====
// Self-checking bench for the burst SRAM port.
// Assumes the controller model drives all pins except clock, reset, strap and sleep.
`timescale 1ns/1ps
module sram_port_tb_top;
    import sram_port_pkg::*;
    logic        clk_in, rst_in, burst_order_in, sleep_request_in;
    logic        clock_qualify_n_in, chip_select_first_n_in;
    logic        chip_select_second_in, chip_select_third_n_in;
    logic        write_select_n_in, advance_or_load_in, output_enable_n_in;
    logic [3:0]  byte_write_select_n_in, parity_io_in, parity_io_out;
    logic [5:0]  addr_in;
    logic [31:0] data_io_in, data_io_out;
    logic        data_io_oe_out, sleeping_out;
    int          n_fail, checked;
    sram_port #(.ADDR_BITS(6)) i_sram_port (.*);
    sram_ctrl_model i_sram_ctrl_model (.*);
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input int k, input logic [5:0] a = '0,
                       input logic [3:0] b = 4'hF, input logic [35:0] d = '0);
        i_sram_ctrl_model.cmd(k, a, b, d);
    endtask
    task automatic idle(input int n);
        repeat (n) cmd(0);
    endtask
    function automatic logic [35:0] pat(input int i);
        return {4'(i) ^ 4'h9, 24'hC3A500 ^ 24'(i * 7), 8'(i)};
    endfunction
    task automatic rd(input logic [5:0] a, input logic [35:0] exp);
        int n;
        n = 0;
        cmd(1, a);
        cmd(1, a);
        cmd(0);
        while (data_io_oe_out !== 1'b1 && n < 10)
        begin
            cmd(0);
            n++;
        end
        check(36'(data_io_oe_out), 36'h1);
        check({parity_io_out, data_io_out}, exp);
        idle(4);
    endtask
    task automatic nodrive(input int k, input logic oe_n);
        int n;
        n = 0;
        i_sram_ctrl_model.set_oe(oe_n);
        cmd(k, 6'h05);
        cmd(k, 6'h05);
        repeat (10)
        begin
            cmd(0);
            if (data_io_oe_out !== 1'b0)
                n++;
        end
        i_sram_ctrl_model.set_oe(1'b0);
        check(36'(n), '0);
    endtask
    task automatic results();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_flood();
        for (int i = 0; i < 40; i++)
            cmd(2, 6'(i), 4'h0, pat(i));
        idle(12);
        rd(6'd0, pat(0));
        rd(6'd39, pat(39));
        $display("test flood done");
    endtask
    task automatic t_lanes();
        cmd(2, 6'd3, 4'b1101, '1);
        idle(12);
        rd(6'd3, pat(3) | {4'h2, 32'h0000FF00});
        $display("test lanes done");
    endtask
    task automatic t_burst();
        logic [5:0] base;
        for (int o = 0; o < 2; o++)
        begin
            base = o ? 6'd12 : 6'd8;
            burst_order_in = o[0];
            idle(4);
            cmd(2, base + 6'd1, 4'h0, pat(50 + 4 * o));
            for (int k = 1; k < 4; k++)
                cmd(3, 6'h3F, 4'h0, pat(50 + 4 * o + k));
            idle(12);
            for (int k = 0; k < 4; k++)
                rd(base + 6'(o ? (1 ^ k) : ((1 + k) & 3)),
                   pat(50 + 4 * o + k));
        end
        $display("test burst done");
    endtask
    task automatic t_stall();
        repeat (6) cmd(4, 6'd20, 4'h0, pat(99));
        idle(6);
        rd(6'd20, pat(20));
        $display("test stall done");
    endtask
    task automatic t_quiet();
        nodrive(1, 1'b1);
        for (int k = 5; k < 8; k++)
            nodrive(k, 1'b0);
        $display("test quiet done");
    endtask
    task automatic t_sleep();
        int n;
        n = 0;
        idle(2);
        sleep_request_in = 1'b1;
        while (sleeping_out !== 1'b1 && n < 16)
        begin
            idle(1);
            n++;
        end
        check(36'(sleeping_out), 36'h1);
        idle(10);
        sleep_request_in = 1'b0;
        n = 0;
        while (sleeping_out !== 1'b0 && n < 16)
        begin
            idle(1);
            n++;
        end
        check(36'(sleeping_out), 36'h0);
        idle(4);
        rd(6'd39, pat(39));
        $display("test sleep done");
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) clk_in = ~clk_in;
    end
    initial
    begin
        #(CLK_PERIOD_NS * 4000);
        n_fail++;
        results();
    end
    initial
    begin
        n_fail = 0;
        checked = 0;
        rst_in = 1'b1;
        burst_order_in = 1'b0;
        sleep_request_in = 1'b0;
        repeat (6) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        idle(1);
        check({data_io_oe_out, sleeping_out}, '0);
        t_flood();
        t_lanes();
        t_burst();
        t_stall();
        t_quiet();
        t_sleep();
        results();
    end
endmodule

// ==== word_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; storage in flip-flops indexed by pointers.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW:0]      count_q;
    logic             push;
    logic             pop;

    assign push         = wr_valid_in && (count_q != (PW+1)'(DEPTH));
    assign pop          = rd_ready_in && (count_q != '0);
    assign wr_ready_out = count_q != (PW+1)'(DEPTH);
    assign rd_valid_out = count_q != '0;
    assign rd_data_out  = mem_q[rd_ptr_q];

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= PW'(wr_ptr_q + 1'b1);
            end
            if (pop)
            begin
                rd_ptr_q <= PW'(rd_ptr_q + 1'b1);
            end
            count_q <= (PW+1)'(count_q + {{PW{1'b0}}, push}
                       - {{PW{1'b0}}, pop});
        end
    end

endmodule
